// >>> hw/fpf_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "fpf_consts.svh"
// Operation
// - Load low and both read enables low: each edge outputs next offset register.
// - Offset reads step empty low, empty high, full low, full high, then wrap.
// - Empty threshold n from empty bytes; almost-empty low while n or fewer words.
// - Almost-empty returns high once n plus one or more words are held.
// - Full threshold m; almost-full low when words reach depth minus m.
// - Almost-full returns high when free locations exceed m.
// - Both thresholds default to 7 until programmed.
// - Empty flag release may slip one edge after a close write.
// - Programmable flag changes may slip one edge.
// - Load pin level at reset release picks load enable or second write enable.
// - Load and write enable low: edges store bytes into the four offsets in turn.
// - Offset sequence pointer persists when load returns high.
module fpf_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire fpf_pkg::fpf_pins_t pins,
    output logic [8:0] data_out,
    output fpf_pkg::fpf_flags_t flags,
    output logic irq
);
    // ***************************************
    // Pin synchronisers and strap
    // ***************************************
    fpf_pkg::fpf_pins_t pin_s1_r, pin_s2_r;
    fpf_pkg::fpf_strap_t st_r, st_nxt;
    logic prog_r, prog_nxt;
    always_comb begin
        st_nxt = st_r;
        prog_nxt = prog_r;
        case (st_r)
            fpf_pkg::FPF_WAIT0: st_nxt = fpf_pkg::FPF_WAIT1;
            fpf_pkg::FPF_WAIT1: begin
                st_nxt = fpf_pkg::FPF_RUN;
                prog_nxt = ~pin_s2_r.load_or_second_write_enable_n;
            end
            fpf_pkg::FPF_RUN: st_nxt = fpf_pkg::FPF_RUN;
            default: st_nxt = fpf_pkg::FPF_WAIT0;
        endcase
    end
    // No reset: the strap must see the pin level held through reset
    always_ff @(posedge hclk) begin
        pin_s1_r <= pins;
        pin_s2_r <= pin_s1_r;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= fpf_pkg::FPF_WAIT0;
            prog_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            prog_r <= prog_nxt;
        end
    end
    // ***************************************
    // Operation decode
    // ***************************************
    logic run, ld_pin, rd_en, wr_fifo, rd_fifo, wr_off, rd_off, ovf, udf;
    fpf_pkg::fpf_flags_t fl_r, fl_nxt;
    assign run = (st_r == fpf_pkg::FPF_RUN);
    assign ld_pin = pin_s2_r.load_or_second_write_enable_n;
    assign rd_en = ~pin_s2_r.read_enable_a_n & ~pin_s2_r.read_enable_b_n;
    assign wr_fifo = run & ~pin_s2_r.primary_write_enable_n & ld_pin & fl_r.full_flag_n;
    assign rd_fifo = run & rd_en & (ld_pin | ~prog_r) & fl_r.empty_flag_n;
    assign wr_off = run & prog_r & ~ld_pin & ~pin_s2_r.primary_write_enable_n;
    // Separate read and write pointers; mixing both confuses software
    assign rd_off = run & prog_r & ~ld_pin & rd_en;
    assign ovf = run & ~pin_s2_r.primary_write_enable_n & ld_pin & ~fl_r.full_flag_n;
    assign udf = run & rd_en & (ld_pin | ~prog_r) & ~fl_r.empty_flag_n;
    // ***************************************
    // Offset registers
    // ***************************************
    logic [7:0] e_lo_r, e_lo_nxt, f_lo_r, f_lo_nxt;
    logic e_hi_r, e_hi_nxt, f_hi_r, f_hi_nxt;
    logic [1:0] wsel_r, wsel_nxt, rsel_r, rsel_nxt;
    logic [8:0] thr_n, thr_m, n_nxt, m_nxt, off_view;
    assign thr_n = {e_hi_r, e_lo_r};
    assign thr_m = {f_hi_r, f_lo_r};
    assign n_nxt = {e_hi_nxt, e_lo_nxt};
    assign m_nxt = {f_hi_nxt, f_lo_nxt};
    always_comb begin
        e_lo_nxt = e_lo_r;
        e_hi_nxt = e_hi_r;
        f_lo_nxt = f_lo_r;
        f_hi_nxt = f_hi_r;
        wsel_nxt = wsel_r;
        rsel_nxt = rsel_r;
        if (wr_off) begin
            case (wsel_r)
                2'h0: e_lo_nxt = pin_s2_r.data[7:0];
                2'h1: e_hi_nxt = pin_s2_r.data[0];
                2'h2: f_lo_nxt = pin_s2_r.data[7:0];
                2'h3: f_hi_nxt = pin_s2_r.data[0];
                default: e_lo_nxt = e_lo_r;
            endcase
            wsel_nxt = wsel_r + 2'h1;
        end
        if (rd_off) begin
            rsel_nxt = rsel_r + 2'h1;
        end
        case (rsel_r)
            2'h0: off_view = {1'b0, e_lo_r};
            2'h1: off_view = {8'h00, e_hi_r};
            2'h2: off_view = {1'b0, f_lo_r};
            default: off_view = {8'h00, f_hi_r};
        endcase
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            e_lo_r <= `FPF_OFF_LO_DEFAULT;
            e_hi_r <= `FPF_OFF_HI_DEFAULT;
            f_lo_r <= `FPF_OFF_LO_DEFAULT;
            f_hi_r <= `FPF_OFF_HI_DEFAULT;
            wsel_r <= 2'h0;
            rsel_r <= 2'h0;
        end else begin
            e_lo_r <= e_lo_nxt;
            e_hi_r <= e_hi_nxt;
            f_lo_r <= f_lo_nxt;
            f_hi_r <= f_hi_nxt;
            wsel_r <= wsel_nxt;
            rsel_r <= rsel_nxt;
        end
    end
    // ***************************************
    // Storage, pointers and flags
    // ***************************************
    logic [8:0] mem [0:511];
    logic [8:0] wptr_r, wptr_nxt, rptr_r, rptr_nxt, dout_r, dout_nxt;
    logic [9:0] cnt_r, cnt_nxt;
    always_comb begin
        wptr_nxt = wr_fifo ? wptr_r + 9'h001 : wptr_r;
        rptr_nxt = rd_fifo ? rptr_r + 9'h001 : rptr_r;
        cnt_nxt = cnt_r + {9'h000, wr_fifo} - {9'h000, rd_fifo};
        dout_nxt = dout_r;
        if (rd_fifo) begin
            dout_nxt = mem[rptr_r];
        end else if (rd_off) begin
            dout_nxt = off_view;
        end
        // Flags from the next count: no overrun, so no slip is taken
        fl_nxt.empty_flag_n = (cnt_nxt != 10'h000);
        fl_nxt.full_flag_n = (cnt_nxt != `FPF_DEPTH);
        fl_nxt.almost_empty_n = (cnt_nxt > {1'b0, n_nxt});
        fl_nxt.almost_full_n = ((`FPF_DEPTH - cnt_nxt) > {1'b0, m_nxt});
    end
    always_ff @(posedge hclk) begin
        if (wr_fifo) begin
            mem[wptr_r] <= pin_s2_r.data;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wptr_r <= 9'h000;
            rptr_r <= 9'h000;
            cnt_r <= 10'h000;
            dout_r <= 9'h000;
            fl_r <= `FPF_FLAGS_RESET;
        end else begin
            wptr_r <= wptr_nxt;
            rptr_r <= rptr_nxt;
            cnt_r <= cnt_nxt;
            dout_r <= dout_nxt;
            fl_r <= fl_nxt;
        end
    end
    assign data_out = dout_r;
    assign flags = fl_r;
    // ***************************************
    // AHB-Lite slave and interrupts
    // ***************************************
    logic [11:0] ph_addr_r, ph_addr_nxt;
    logic ph_wr_r, ph_wr_nxt, ph_rd_r, ph_rd_nxt;
    logic [3:0] ist_r, ist_nxt, imask_r, imask_nxt, evt, clr;
    logic take;
    assign take = hsel & hready & htrans[1];
    assign evt = {udf, ovf, fl_r.almost_full_n & ~fl_nxt.almost_full_n,
                  fl_r.almost_empty_n & ~fl_nxt.almost_empty_n};
    assign clr = (ph_wr_r && ph_addr_r == `FPF_A_IRQ_STAT) ? hwdata[3:0] : 4'h0;
    always_comb begin
        ph_addr_nxt = take ? haddr[11:0] : ph_addr_r;
        ph_wr_nxt = take & hwrite;
        ph_rd_nxt = take & ~hwrite;
        // Set wins over a same-cycle clear
        ist_nxt = (ist_r & ~clr) | evt;
        imask_nxt = imask_r;
        if (ph_wr_r && ph_addr_r == `FPF_A_IRQ_MASK) begin
            imask_nxt = hwdata[3:0];
        end
        hrdata = 32'h0000_0000;
        if (ph_rd_r) begin
            case (ph_addr_r)
                `FPF_A_STATUS: hrdata = {15'h0, prog_r, 2'h0, cnt_r, fl_r};
                `FPF_A_IRQ_STAT: hrdata = {28'h0000000, ist_r};
                `FPF_A_IRQ_MASK: hrdata = {28'h0000000, imask_r};
                `FPF_A_THRESH: hrdata = {7'h00, thr_m, 7'h00, thr_n};
                default: hrdata = 32'h0000_0000;
            endcase
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_addr_r <= 12'h000;
            ph_wr_r <= 1'b0;
            ph_rd_r <= 1'b0;
            ist_r <= 4'h0;
            imask_r <= 4'h0;
        end else begin
            ph_addr_r <= ph_addr_nxt;
            ph_wr_r <= ph_wr_nxt;
            ph_rd_r <= ph_rd_nxt;
            ist_r <= ist_nxt;
            imask_r <= imask_nxt;
        end
    end
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign irq = |(ist_r & imask_r);
    // ***************************************
    // Assertions
    // ***************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    ae_level_a: assert property (fl_r.almost_empty_n == (cnt_r > {1'b0, thr_n}))
        else $error("almost empty wrong");
    ae_rise_a: assert property ($rose(fl_r.almost_empty_n) |->
        cnt_r == {1'b0, thr_n} + 10'h001 || $changed(thr_n))
        else $error("almost empty rose at wrong count");
    af_level_a: assert property (fl_r.almost_full_n ==
        ((`FPF_DEPTH - cnt_r) > {1'b0, thr_m}))
        else $error("almost full wrong");
    af_rise_a: assert property ($rose(fl_r.almost_full_n) |->
        (`FPF_DEPTH - cnt_r) > {1'b0, thr_m})
        else $error("almost full rose early");
    dflt_thr_a: assert property (!run |->
        thr_n == `FPF_OFF_DEFAULT && thr_m == `FPF_OFF_DEFAULT)
        else $error("default threshold lost");
    off_wr_seq_a: assert property (wr_off |=> wsel_r == $past(wsel_r) + 2'h1)
        else $error("offset write pointer stuck");
    off_rd_data_a: assert property (rd_off |=> data_out == $past(off_view))
        else $error("offset read data wrong");
    seq_hold_a: assert property (!wr_off && !rd_off |=>
        $stable(wsel_r) && $stable(rsel_r))
        else $error("sequence pointer moved");
    hi_bits_a: assert property (rd_off && rsel_r[0] |=> data_out[8:1] == 8'h00)
        else $error("high offset upper bits set");
    strap_a: assert property (st_r == fpf_pkg::FPF_WAIT1 |=> prog_r == !$past(ld_pin))
        else $error("strap not captured");
    empty_a: assert property (fl_r.empty_flag_n == (cnt_r != 10'h000))
        else $error("empty flag wrong");
    irq_a: assert property (|(evt & imask_r) |=> ##[0:1] irq)
        else $error("irq missing");
    cv_off_wrap_c: cover property (wr_off && wsel_r == 2'h3);
    cv_af_c: cover property ($fell(fl_r.almost_full_n));
    cv_ae_c: cover property ($rose(fl_r.almost_empty_n));
    cv_rd_off_c: cover property (rd_off ##1 rd_off);
endmodule
`default_nettype wire

// >>> inc/fpf_consts.svh
`ifndef FPF_CONSTS_SVH
`define FPF_CONSTS_SVH
`define FPF_DEPTH 10'h200
`define FPF_AW 9
`define FPF_DW 9
`define FPF_OFF_DEFAULT 9'h007
`define FPF_OFF_LO_DEFAULT 8'h07
`define FPF_OFF_HI_DEFAULT 1'b0
`define FPF_FLAGS_RESET 4'h5
`define FPF_A_STATUS 12'h000
`define FPF_A_IRQ_STAT 12'h004
`define FPF_A_IRQ_MASK 12'h008
`define FPF_A_THRESH 12'h00c
`define FPF_EV_AE 0
`define FPF_EV_AF 1
`define FPF_EV_OVF 2
`define FPF_EV_UDF 3
`define FPF_NEV 4
`define FPF_TH_M_LSB 16
`endif

// >>> inc/fpf_pkg.sv
`include "fpf_consts.svh"
package fpf_pkg;
    typedef struct packed {
        logic [8:0] data;
        logic primary_write_enable_n;
        logic load_or_second_write_enable_n;
        logic read_enable_a_n;
        logic read_enable_b_n;
    } fpf_pins_t;
    typedef struct packed {
        logic empty_flag_n;
        logic full_flag_n;
        logic almost_empty_n;
        logic almost_full_n;
    } fpf_flags_t;
    typedef enum logic [1:0] {FPF_WAIT0, FPF_WAIT1, FPF_RUN} fpf_strap_t;
endpackage

// >>> tb/fpf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// Host pin driver
// ****************
module fpf_host_model (
    input wire logic hclk,
    output fpf_pkg::fpf_pins_t pins
);
    logic ld_idle = 1'h0;
    initial pins = {9'h000, 1'h1, 1'h0, 1'h1, 1'h1};
    // Level set before reset release picks the load role
    task automatic rest(input logic l);
        ld_idle = l;
        pins <= {9'h000, 1'h1, l, 1'h1, 1'h1};
    endtask
    // One request for k edges; never a write and a read together
    task automatic op(input logic w, input logic l, input logic r, input logic [8:0] d,
                      input int k);
        @(posedge hclk);
        pins <= {d, w, l, r, r};
        repeat (k) @(posedge hclk);
        // Released data lines show the inverse, not a stale copy
        pins <= {~d, 1'h1, ld_idle, 1'h1, 1'h1};
        repeat (4) @(posedge hclk);
    endtask
endmodule
`default_nettype wire

// >>> tb/tb_fpf_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_fpf_top;
    logic hclk = 1'h0;
    logic hresetn = 1'h0;
    logic hsel = 1'h0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic irq;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic [8:0] data_out;
    fpf_pkg::fpf_pins_t pins;
    fpf_pkg::fpf_flags_t flags;
    int num_errors = 0;
    int n_checks = 0;
    always #2.5 hclk = ~hclk;
    fpf_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .pins(pins), .data_out(data_out), .flags(flags), .irq(irq));
    fpf_host_model host_u (.hclk(hclk), .pins(pins));
    // ****************
    // Shared tasks
    // ****************
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input logic [8:0] got, input logic [8:0] exp);
        chk_reg({23'h0, got}, {23'h0, exp});
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        @(posedge hclk);
        while (hreadyout !== 1'h1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'h1) @(posedge hclk);
        rd = hrdata;
        chk_reg({31'h0, hresp}, 32'h0); // always OKAY
        hsel <= 1'h0;
    endtask
    task automatic status(input logic p, input int c, input int n, input int m);
        logic [3:0] f;
        f = {c != 0, c != 512, c > n, c < 512 - m};
        bus(1'h0, 32'h0, 32'h0);
        chk_reg(rd, {15'h0, p, 2'h0, c[9:0], f});
        chk_pin({5'h00, flags}, {5'h00, f});
    endtask
    task automatic do_reset(input logic l);
        hresetn <= 1'h0;
        host_u.rest(l);
        repeat (16) @(posedge hclk);
        hresetn <= 1'h1;
        repeat (4) @(posedge hclk);
    endtask
    task automatic test_done();
        $display("checks=%0d errors=%0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ****************
    // Scenarios
    // ****************
    task automatic t_default();
        status(1'h1, 0, 7, 7);
        bus(1'h0, 32'hc, 32'h0);
        chk_reg(rd, 32'h0007_0007);
        bus(1'h0, 32'h10, 32'h0);
        chk_reg(rd, 32'h0); // unmapped
        bus(1'h1, 32'h4, 32'hf);
        bus(1'h1, 32'h8, 32'h2);
        bus(1'h0, 32'h8, 32'h0);
        chk_reg(rd, 32'h2); // mask readback
    endtask
    task automatic t_prog();
        logic [8:0] wv[4] = '{9'h003, 9'h0fe, 9'h005, 9'h101};
        logic [8:0] ev[4] = '{9'h003, 9'h000, 9'h005, 9'h001};
        // Load goes high between writes to prove the pointer is kept
        host_u.ld_idle = 1'h1;
        for (int i = 0; i < 4; i++) host_u.op(1'h0, 1'h0, 1'h1, wv[i], 1);
        bus(1'h0, 32'hc, 32'h0);
        chk_reg(rd, 32'h0105_0003);
        for (int i = 0; i < 4; i++) begin
            host_u.op(1'h1, 1'h0, 1'h0, 9'h000, 1);
            chk_pin(data_out, ev[i]);
        end
    endtask
    task automatic t_fill();
        host_u.op(1'h0, 1'h1, 1'h1, 9'h1a5, 3);
        status(1'h1, 3, 3, 261);
        host_u.op(1'h0, 1'h1, 1'h1, 9'h1a5, 1);
        status(1'h1, 4, 3, 261);
        chk_pin({8'h00, irq}, 9'h000); // no event: almost-empty rising sets none
        host_u.op(1'h0, 1'h1, 1'h1, 9'h1a5, 246);
        status(1'h1, 250, 3, 261);
        host_u.op(1'h0, 1'h1, 1'h1, 9'h1a5, 1);
        status(1'h1, 251, 3, 261);
        chk_pin({8'h00, irq}, 9'h001); // unmasked event
        bus(1'h0, 32'h4, 32'h0);
        chk_reg(rd, 32'h2); // sticky almost-full event
        bus(1'h1, 32'h4, 32'h2);
        repeat (2) @(posedge hclk);
        chk_pin({8'h00, irq}, 9'h000); // write one clears
        host_u.op(1'h1, 1'h1, 1'h0, 9'h000, 1);
        chk_pin(data_out, 9'h1a5); // first word out
        status(1'h1, 250, 3, 261);
    endtask
    task automatic t_two();
        do_reset(1'h1);
        status(1'h0, 0, 7, 7);
        host_u.op(1'h1, 1'h1, 1'h0, 9'h000, 1);
        bus(1'h0, 32'h4, 32'h0);
        chk_reg(rd, 32'h8); // read while empty
        host_u.op(1'h0, 1'h0, 1'h1, 9'h011, 1);
        status(1'h0, 0, 7, 7);
        host_u.op(1'h0, 1'h1, 1'h1, 9'h011, 1);
        status(1'h0, 1, 7, 7);
    endtask
    initial begin
        do_reset(1'h0);
        t_default();
        t_prog();
        t_fill();
        t_two();
        test_done();
    end
    initial begin
        #100000;
        num_errors++;
        test_done();
    end
endmodule
`default_nettype wire
